// ---- intc_core.sv ----
// nested priority interrupt controller: latches, arbitration, entry sequence
// assumes the core pulses boundary, trap, return and stack-done on ref_clk_i
//
// Function
// - priority field in cc bits five and three
// - four level codes, 11 masks all
// - sixteen fixed vectors FFE0h to FFFFh
// - service starts only at instruction end
// - stack pc, x, a, cc on entry
// - entry loads priority from vector setting
// - vector address loaded after stacking completes
// - return restores popped priority bits
// - highest software level, then hardware order
// - unserved edge and trap requests stay latched until chosen
// - pin, reset, trap rank top level
// - reset and trap ignore level, set 3
// - trap on instruction; pin preempts trap
// - reset highest, starts at level three
// - maskable needs enable and higher level
// - pin edge served like trap
// - edge requests latched, cleared on entry
// - grouped pins ored onto one line
// - peripheral request needs flag and enable
// - clearing sequence drops pending peripheral request
// - any wakes wait; capable only wake halt
// - after halt serve capable request first
// - fixed order pin, trap, then levels
// - level-zero code writes to settings ignored
module intc_core
    import intc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // core side
    input wire logic instr_boundary_i,
    input wire logic trap_exec_i,
    input wire logic stack_done_i,
    input wire logic return_from_service_i,
    input wire logic [7:0] cc_pop_i,
    input wire logic cc_wr_i,
    input wire logic [7:0] cc_wr_data_i,
    input wire logic wait_enter_i,
    input wire logic halt_enter_i,
    // priority settings write port
    input wire logic prio_wr_i,
    input wire logic [3:0] prio_wr_idx_i,
    input wire logic [1:0] prio_wr_data_i,
    // pins
    input wire logic top_level_pin_irq_i,
    input wire logic tli_rise_sel_i,
    input wire logic tli_en_i,
    input wire logic [NUM_PINS-1:0] ext_pins_i,
    input wire logic [NUM_PINS-1:0] ext_pin_sel_i,
    input wire logic [2*NUM_EXT-1:0] ext_irq_sense_ctrl_i,
    // peripherals
    input wire logic [NUM_PERIPH-1:0] periph_flag_i,
    input wire logic [NUM_PERIPH-1:0] periph_en_i,
    input wire logic [NUM_PERIPH-1:0] periph_clr_i,
    // service sequence
    output logic svc_busy_o,
    output logic svc_stack_o,
    output logic svc_load_o,
    output logic [15:0] svc_vec_o,
    output logic wake_o,
    // state
    output logic [1:0] cur_prio_field_o,
    output logic [7:0] condition_code_reg_o,
    output logic [2*NUM_MASK-1:0] vector_prio_settings_o
);

    // ==================================================================
    // declarations
    svc_state_e state_r;
    lp_mode_e lp_r;
    logic [1:0] cur_prio_r;
    logic [2*NUM_MASK-1:0] prio_r;
    logic [NUM_PINS:0] pin_meta_r;
    logic [NUM_PINS:0] pin_sync_r;
    logic tli_prev_r;
    logic tli_pend_r;
    logic trap_pend_r;
    logic [NUM_EXT-1:0] line_prev_r;
    logic [NUM_EXT-1:0] ext_pend_r;
    logic [NUM_EXT-1:0] ext_req;
    logic [NUM_EXT-1:0] ext_clr;
    logic [NUM_PERIPH-1:0] per_pend_r;
    logic [NUM_MASK-1:0] mask_pend;
    logic [NUM_MASK-1:0] allow;
    logic halt_first_r;
    logic arb_hit;
    logic [3:0] arb_idx;
    logic [1:0] arb_code;
    logic tli_edge;
    logic tli_go;
    logic any_req;
    logic take;
    logic [15:0] tgt_vec_r;
    logic [1:0] tgt_prio_r;
    logic [3:0] tgt_idx_r;
    logic tgt_mask_r;
    logic wake_req;

    // ==================================================================
    // pin synchronisers, pin interrupt in the top bit
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end
        else
        begin
            pin_meta_r <= {top_level_pin_irq_i, ext_pins_i};
            pin_sync_r <= pin_meta_r;
        end
    end

    // ==================================================================
    // top-level pin: edge latch, cleared when its routine is entered
    assign tli_edge = tli_rise_sel_i ? (pin_sync_r[NUM_PINS] && !tli_prev_r)
                                     : (!pin_sync_r[NUM_PINS] && tli_prev_r);

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tli_prev_r <= 1'b0;
            tli_pend_r <= 1'b0;
        end
        else
        begin
            tli_prev_r <= pin_sync_r[NUM_PINS];
            // a new edge in the entry cycle survives the clear
            tli_pend_r <= (tli_pend_r && !(take && tli_go)) || tli_edge;
        end
    end

    // ==================================================================
    // software trap, taken at the end of the trap instruction
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            trap_pend_r <= 1'b0;
        end
        else
        begin
            trap_pend_r <= (trap_pend_r && !(take && !tli_go && trap_pend_r))
                           || trap_exec_i;
        end
    end

    // ==================================================================
    // external lines
    generate
        for (genvar l = 0; l < NUM_EXT; l++)
        begin : g_ext
            logic now;
            logic rise;
            logic fall;
            logic set;
            logic [1:0] sense;
            assign sense = ext_irq_sense_ctrl_i[2*l+:2];
            assign now = |(pin_sync_r[l*PINS_PER_LINE+:PINS_PER_LINE]
                           & ext_pin_sel_i[l*PINS_PER_LINE+:PINS_PER_LINE]);
            assign rise = now && !line_prev_r[l];
            assign fall = !now && line_prev_r[l];
            assign set = ((sense == SENSE_RISE) && rise) || ((sense == SENSE_FALL) && fall)
                         || ((sense == SENSE_BOTH) && (rise || fall));
            assign ext_clr[l] = take && tgt_sel_ext(l);
            // low level is not latched: it requests while the line stays low
            assign ext_req[l] = ext_pend_r[l] || ((sense == SENSE_LOW) && !now);

            always_ff @(posedge ref_clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    line_prev_r[l] <= 1'b0;
                    ext_pend_r[l] <= 1'b0;
                end
                else
                begin
                    line_prev_r[l] <= now;
                    ext_pend_r[l] <= (ext_pend_r[l] && !ext_clr[l]) || set;
                end
            end
        end
    endgenerate

    // true when the arbitration in this cycle picks external line l
    function automatic logic tgt_sel_ext(input int l);
        return arb_hit && !trap_pend_r && !tli_go && (arb_idx == 4'(EXT_BASE + l));
    endfunction

    // ==================================================================
    // peripheral latches: the clearing sequence wins over a new flag
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            per_pend_r <= '0;
        end
        else
        begin
            per_pend_r <= ~periph_clr_i & (per_pend_r | (periph_flag_i & periph_en_i));
        end
    end

    assign mask_pend = {per_pend_r[NUM_PERIPH-1:1], ext_req, per_pend_r[0], tli_pend_r};

    // ==================================================================
    // vector priority settings
    generate
        for (genvar v = 0; v < NUM_MASK; v++)
        begin : g_prio
            always_ff @(posedge ref_clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    prio_r[2*v+:2] <= PRIO_RESET;
                end
                else if (prio_wr_i && (prio_wr_idx_i == 4'(v)) && (prio_wr_data_i != PRIO_LVL0))
                begin
                    prio_r[2*v+:2] <= prio_wr_data_i;
                end
            end
        end
    endgenerate

    // ==================================================================
    // arbitration
    assign allow = halt_first_r ? HALT_CAPABLE : {NUM_MASK{1'b1}};

    intc_arbiter u_arb (
        .pend_i(mask_pend),
        .allow_i(allow),
        .prio_i(prio_r),
        .cur_prio_i(cur_prio_r),
        .hit_o(arb_hit),
        .idx_o(arb_idx),
        .code_o(arb_code)
    );

    // the pin ignores the current level, so it can preempt a trap routine
    assign tli_go = tli_pend_r && tli_en_i && allow[0];
    assign any_req = trap_pend_r || tli_go || arb_hit;
    assign take = (state_r == ST_IDLE) && (lp_r == LP_RUN) && instr_boundary_i && any_req;

    // ==================================================================
    // service sequence
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_RST;
            tgt_vec_r <= VEC_RESET;
            tgt_prio_r <= PRIO_LVL3;
            tgt_idx_r <= 4'h0;
            tgt_mask_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                ST_RST:
                begin
                    tgt_vec_r <= VEC_RESET;
                    state_r <= ST_LOAD;
                end
                ST_IDLE:
                begin
                    if (take)
                    begin
                        state_r <= ST_STACK;
                        tgt_mask_r <= 1'b0;
                        tgt_prio_r <= PRIO_LVL3;
                        if (tli_go)
                        begin
                            tgt_vec_r <= VEC_TLI;
                        end
                        else if (trap_pend_r)
                        begin
                            tgt_vec_r <= VEC_TRAP;
                        end
                        else
                        begin
                            tgt_vec_r <= VEC_TLI - {11'h000, arb_idx, 1'b0};
                            tgt_prio_r <= arb_code;
                            tgt_idx_r <= arb_idx;
                            tgt_mask_r <= 1'b1;
                        end
                    end
                end
                ST_STACK:
                begin
                    if (stack_done_i)
                    begin
                        state_r <= ST_LOAD;
                    end
                end
                ST_LOAD:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // outputs of the sequence, all registered
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            svc_busy_o <= 1'b1;
            svc_stack_o <= 1'b0;
            svc_load_o <= 1'b0;
            svc_vec_o <= VEC_RESET;
        end
        else
        begin
            svc_busy_o <= take || (state_r == ST_STACK) || (state_r == ST_RST);
            svc_stack_o <= take || ((state_r == ST_STACK) && !stack_done_i);
            svc_load_o <= (state_r == ST_RST) || ((state_r == ST_STACK) && stack_done_i);
            if ((state_r == ST_RST) || ((state_r == ST_STACK) && stack_done_i))
            begin
                svc_vec_o <= (state_r == ST_RST) ? VEC_RESET : tgt_vec_r;
            end
        end
    end

    // ==================================================================
    // current priority field
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cur_prio_r <= CUR_PRIO_RESET;
        end
        else if ((state_r == ST_STACK) && stack_done_i)
        begin
            cur_prio_r <= tgt_prio_r;
        end
        else if (return_from_service_i)
        begin
            cur_prio_r <= {cc_pop_i[CC_PRIO_HI_BIT], cc_pop_i[CC_PRIO_LO_BIT]};
        end
        else if (cc_wr_i)
        begin
            cur_prio_r <= {cc_wr_data_i[CC_PRIO_HI_BIT], cc_wr_data_i[CC_PRIO_LO_BIT]};
        end
        else if (wait_enter_i || halt_enter_i)
        begin
            cur_prio_r <= PRIO_LVL0;
        end
    end

    // ==================================================================
    // low power modes
    // in halt only capable vectors count; any serviceable request ends wait
    assign wake_req = (lp_r == LP_HALT) ? (tli_go || |(mask_pend & HALT_CAPABLE))
                                        : any_req;

    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            lp_r <= LP_RUN;
            halt_first_r <= 1'b0;
            wake_o <= 1'b0;
        end
        else
        begin
            wake_o <= (lp_r != LP_RUN) && wake_req;
            unique case (lp_r)
                LP_RUN:
                begin
                    if (halt_enter_i)
                    begin
                        lp_r <= LP_HALT;
                    end
                    else if (wait_enter_i)
                    begin
                        lp_r <= LP_WAIT;
                    end
                end
                LP_WAIT:
                begin
                    if (wake_req)
                    begin
                        lp_r <= LP_RUN;
                    end
                end
                LP_HALT:
                begin
                    if (wake_req)
                    begin
                        lp_r <= LP_RUN;
                    end
                end
                default:
                begin
                    lp_r <= LP_RUN;
                end
            endcase
            // the first service after halt must be a capable one
            if ((lp_r == LP_HALT) && wake_req)
            begin
                halt_first_r <= 1'b1;
            end
            else if (take)
            begin
                halt_first_r <= 1'b0;
            end
        end
    end

    // ==================================================================
    // state views
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cur_prio_field_o <= CUR_PRIO_RESET;
            condition_code_reg_o <= 8'h28;
            vector_prio_settings_o <= {NUM_MASK{PRIO_RESET}};
        end
        else
        begin
            cur_prio_field_o <= cur_prio_r;
            condition_code_reg_o <= 8'h00;
            condition_code_reg_o[CC_PRIO_HI_BIT] <= cur_prio_r[1];
            condition_code_reg_o[CC_PRIO_LO_BIT] <= cur_prio_r[0];
            vector_prio_settings_o <= prio_r;
        end
    end

endmodule // intc_core

// ---- intc_pkg.sv ----
// constants, encodings and helpers shared by the nested interrupt controller
// assumes one cpu clock domain and a core that reports instruction boundaries
package intc_pkg;

    // ==================================================================
    // vector population
    localparam int NUM_MASK = 14;
    localparam int NUM_EXT = 4;
    localparam int EXT_BASE = 2;
    localparam int PINS_PER_LINE = 4;
    localparam int NUM_PERIPH = 9;
    localparam int NUM_PINS = NUM_EXT * PINS_PER_LINE;

    // ==================================================================
    // condition-code interrupt bits and level codes
    localparam int CC_PRIO_HI_BIT = 5;
    localparam int CC_PRIO_LO_BIT = 3;
    localparam logic [1:0] PRIO_LVL0 = 2'h2;
    localparam logic [1:0] PRIO_LVL1 = 2'h1;
    localparam logic [1:0] PRIO_LVL2 = 2'h0;
    localparam logic [1:0] PRIO_LVL3 = 2'h3;
    localparam logic [1:0] PRIO_RESET = 2'h3;
    localparam logic [1:0] CUR_PRIO_RESET = 2'h3;

    // ==================================================================
    // vector addresses, fixed hardware order (higher address wins, except the pin goes before the trap)
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP = 16'hFFFC;
    localparam logic [15:0] VEC_TLI = 16'hFFFA;
    localparam logic [15:0] VEC_LOW = 16'hFFE0;

    // vectors able to end halt: pin interrupt, time base and the external lines
    localparam logic [NUM_MASK-1:0] HALT_CAPABLE = 14'h003F;

    // ==================================================================
    // external line sensitivity, two bits per line
    localparam logic [1:0] SENSE_LOW = 2'h0;
    localparam logic [1:0] SENSE_RISE = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;

    typedef enum logic [2:0] {
        ST_RST,
        ST_IDLE,
        ST_STACK,
        ST_LOAD
    } svc_state_e;

    typedef enum logic [1:0] {
        LP_RUN,
        LP_WAIT,
        LP_HALT
    } lp_mode_e;

    // level number 0..3 of a two-bit priority code
    function automatic logic [1:0] lvl_of(input logic [1:0] code);
        logic [1:0] lvl;
        lvl = 2'h0;
        unique case (code)
            PRIO_LVL0: lvl = 2'h0;
            PRIO_LVL1: lvl = 2'h1;
            PRIO_LVL2: lvl = 2'h2;
            PRIO_LVL3: lvl = 2'h3;
        endcase
        return lvl;
    endfunction

endpackage

// ---- intc_arbiter.sv ----
// combinational pick of the maskable vector to serve next
// assumes pending, priority and filter inputs come from registers of the caller
module intc_arbiter
    import intc_pkg::*;
(
    // requests
    input wire logic [NUM_MASK-1:0] pend_i,
    input wire logic [NUM_MASK-1:0] allow_i,
    input wire logic [2*NUM_MASK-1:0] prio_i,
    input wire logic [1:0] cur_prio_i,
    // result
    output logic hit_o,
    output logic [3:0] idx_o,
    output logic [1:0] code_o
);

    // ==================================================================
    // scan from lowest hardware priority up, ties go to the later one
    always_comb
    begin
        logic [1:0] best;
        logic [1:0] lvl;
        best = 2'h0;
        lvl = 2'h0;
        hit_o = 1'b0;
        idx_o = 4'h0;
        code_o = PRIO_LVL3;
        // slot 0 is the pin interrupt, its setting plays no part here
        for (int i = NUM_MASK - 1; i >= 1; i--)
        begin
            lvl = lvl_of(prio_i[2*i+:2]);
            if (pend_i[i] && allow_i[i] && (lvl > lvl_of(cur_prio_i))
                && (!hit_o || lvl >= best))
            begin
                hit_o = 1'b1;
                best = lvl;
                idx_o = 4'(i);
                code_o = prio_i[2*i+:2];
            end
        end
    end

endmodule // intc_arbiter

// ---- intc_core_asserts.sv ----
// concurrent checks on the ports of intc_core
// assumes a single ref_clk_i domain with rst_i asynchronous active high
module intc_core_asserts
    import intc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // watched ports
    input wire logic instr_boundary_i,
    input wire logic stack_done_i,
    input wire logic return_from_service_i,
    input wire logic [7:0] cc_pop_i,
    input wire logic prio_wr_i,
    input wire logic [1:0] prio_wr_data_i,
    input wire logic svc_busy_o,
    input wire logic svc_stack_o,
    input wire logic svc_load_o,
    input wire logic [15:0] svc_vec_o,
    input wire logic [1:0] cur_prio_field_o,
    input wire logic [7:0] condition_code_reg_o,
    input wire logic [2*NUM_MASK-1:0] vector_prio_settings_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // ==================================================================
    // entry sequence
    AST_START_AT_BOUNDARY: assert property ($rose(svc_stack_o) |-> $past(instr_boundary_i))
        else $error("stacking began away from an instruction boundary");
    AST_STACK_BUSY: assert property (svc_stack_o |-> svc_busy_o)
        else $error("stack request outside a busy sequence");
    AST_LOAD_AFTER_STACK: assert property (svc_stack_o && stack_done_i |=> svc_load_o)
        else $error("vector load did not follow stacking");
    AST_LOAD_ONE_CYCLE: assert property (svc_load_o |=> !svc_load_o)
        else $error("vector load held longer than one cycle");
    AST_VEC_RANGE: assert property (svc_load_o |-> svc_vec_o >= VEC_LOW && !svc_vec_o[0])
        else $error("vector outside the fixed table");
    AST_TOP_LEVEL3: assert property (svc_load_o && svc_vec_o >= VEC_TLI |=> cur_prio_field_o == PRIO_LVL3)
        else $error("top source entered below level three");

    // ==================================================================
    // level bookkeeping
    AST_RETURN_RESTORE: assert property (return_from_service_i && !svc_busy_o && !instr_boundary_i
        |-> ##2 cur_prio_field_o == {$past(cc_pop_i[5], 2), $past(cc_pop_i[3], 2)})
        else $error("return did not restore the popped level");
    AST_CC_BITS: assert property (condition_code_reg_o
        == {2'h0, cur_prio_field_o[1], 1'h0, cur_prio_field_o[0], 3'h0})
        else $error("level field not at bits five and three");
    AST_LVL0_IGNORED: assert property (prio_wr_i && prio_wr_data_i == PRIO_LVL0
        |=> $stable(vector_prio_settings_o) [*2])
        else $error("level zero code written into a setting");
endmodule // intc_core_asserts

bind intc_core intc_core_asserts chk (.*);

// ---- core_model.sv ----
// stand-in for the cpu core: acknowledges stack requests after a lag
// assumes the request holds until the edge after the acknowledge
module core_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // stacking handshake
    input wire logic stack_req_i,
    input wire logic [1:0] lag_i,
    output logic stack_done_o
);
    logic [1:0] wait_r;
    logic sent_r;

    // one acknowledge per request; sent_r stops a second one while it drains
    always_ff @(posedge ref_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wait_r <= 2'h0;
            sent_r <= 1'b0;
            stack_done_o <= 1'b0;
        end
        else if (!stack_req_i)
        begin
            wait_r <= 2'h0;
            sent_r <= 1'b0;
            stack_done_o <= 1'b0;
        end
        else if (stack_done_o)
            stack_done_o <= 1'b0;
        else if (!sent_r && wait_r == lag_i)
        begin
            stack_done_o <= 1'b1;
            sent_r <= 1'b1;
        end
        else
            wait_r <= wait_r + 2'h1;
    end
endmodule // core_model

// ---- nested_priority_interrupt_controller_test.sv ----
// self-checking bench for intc_core; plays the core except stacking
// assumes core_model answers stack requests and intc_core_asserts is bound
module nested_priority_interrupt_controller_test import intc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 0, rst_i = 1, stack_done_i, svc_busy_o, svc_stack_o, svc_load_o, wake_o;
    logic instr_boundary_i = 0, trap_exec_i = 0, return_from_service_i = 0, cc_wr_i = 0;
    logic wait_enter_i = 0, halt_enter_i = 0, prio_wr_i = 0;
    logic top_level_pin_irq_i = 0, tli_rise_sel_i = 1, tli_en_i = 0;
    logic [7:0] cc_pop_i = 8'h00, cc_wr_data_i = 8'h00, condition_code_reg_o;
    logic [3:0] prio_wr_idx_i = 4'h0;
    logic [1:0] prio_wr_data_i = 2'h0, lag_i = 2'h0, cur_prio_field_o;
    logic [15:0] ext_pins_i = 16'h0000, ext_pin_sel_i = 16'h0002, svc_vec_o;
    logic [7:0] ext_irq_sense_ctrl_i = {SENSE_FALL, SENSE_FALL, SENSE_FALL, SENSE_RISE};
    logic [8:0] periph_flag_i = 9'h000, periph_en_i = 9'h002, periph_clr_i = 9'h000;
    logic [27:0] vector_prio_settings_o, exp_set = 28'hFFFFFFF;
    int err_total = 0, comparisons = 0, cyc = 0;

    intc_core dut (.*);
    core_model partner (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .stack_req_i(svc_stack_o),
        .lag_i(lag_i), .stack_done_o(stack_done_i));

    always #4 ref_clk_i = ~ref_clk_i;

    // ==================================================================
    // helpers
    task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task conclude;
        $display("errors %0d, comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    task prio_set(input logic [3:0] idx, input logic [1:0] val);
        @(posedge ref_clk_i);
        prio_wr_i <= 1'b1;
        prio_wr_idx_i <= idx;
        prio_wr_data_i <= val;
        @(posedge ref_clk_i);
        prio_wr_i <= 1'b0;
        tick(3);
    endtask

    task ret(input logic [7:0] cc);
        @(posedge ref_clk_i);
        return_from_service_i <= 1'b1;
        cc_pop_i <= cc;
        @(posedge ref_clk_i);
        return_from_service_i <= 1'b0;
        tick(3);
    endtask

    // boundary pulse, then expect an entry (vector and level) or none
    task serve(input logic hit, input logic [15:0] vec, input logic [1:0] lvl);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        instr_boundary_i <= 1'b1;
        @(posedge ref_clk_i);
        instr_boundary_i <= 1'b0;
        while (svc_load_o !== 1'b1 && n < 12)
        begin
            @(posedge ref_clk_i);
            n++;
        end
        check(n < 12, hit, "entry taken");
        if (hit)
        begin
            check(svc_vec_o, vec, "vector");
            tick(2);
            check(cur_prio_field_o, lvl, "level on entry");
        end
    endtask

    // counts wake cycles over a fixed span
    task wake_seen(input logic exp);
        int n;
        n = 0;
        repeat (12)
        begin
            @(posedge ref_clk_i);
            n += (wake_o === 1'b1);
        end
        check(n > 0, exp, "wake");
    endtask

    // ==================================================================
    // main sequence
    initial
    begin
        tick(10);
        check(cur_prio_field_o, PRIO_LVL3, "reset level");
        check(condition_code_reg_o, 8'h28, "reset cc");
        check(vector_prio_settings_o, exp_set, "reset settings");
        rst_i <= 1'b0;
        while (svc_load_o !== 1'b1 && cyc < 40) @(posedge ref_clk_i);
        check(svc_load_o, 1'b1, "reset load");
        check(svc_vec_o, VEC_RESET, "reset vector");
        tick(3);
        check(svc_busy_o, 1'b0, "idle after reset");
        prio_set(4'h1, PRIO_LVL0);
        check(vector_prio_settings_o, exp_set, "level zero write");
        prio_set(4'h1, PRIO_LVL1);
        prio_set(4'h2, PRIO_LVL2);
        prio_set(4'h6, PRIO_LVL2);
        exp_set[3:2] = PRIO_LVL1;
        exp_set[5:4] = PRIO_LVL2;
        exp_set[13:12] = PRIO_LVL2;
        check(vector_prio_settings_o, exp_set, "settings");
        periph_flag_i <= 9'h002;
        ext_pins_i <= 16'h0002;
        tick(5);
        serve(0, 16'h0000, 2'h0);
        @(posedge ref_clk_i);
        cc_wr_i <= 1'b1;
        cc_wr_data_i <= 8'h20;
        @(posedge ref_clk_i);
        cc_wr_i <= 1'b0;
        tick(3);
        check(cur_prio_field_o, PRIO_LVL0, "level after cc write");
        serve(1, 16'hFFF6, PRIO_LVL2);
        serve(0, 16'h0000, 2'h0);
        ret(8'h20);
        serve(1, 16'hFFEE, PRIO_LVL2);
        periph_flag_i <= 9'h000;
        periph_clr_i <= 9'h002;
        @(posedge ref_clk_i);
        periph_clr_i <= 9'h000;
        ret(8'h20);
        serve(0, 16'h0000, 2'h0);
        periph_flag_i <= 9'h001;
        serve(0, 16'h0000, 2'h0);
        periph_en_i <= 9'h003;
        serve(1, 16'hFFF8, PRIO_LVL1);
        periph_flag_i <= 9'h000;
        periph_clr_i <= 9'h001;
        lag_i <= 2'h3;
        @(posedge ref_clk_i);
        periph_clr_i <= 9'h000;
        trap_exec_i <= 1'b1;
        @(posedge ref_clk_i);
        trap_exec_i <= 1'b0;
        serve(1, VEC_TRAP, PRIO_LVL3);
        tli_en_i <= 1'b1;
        top_level_pin_irq_i <= 1'b1;
        tick(5);
        serve(1, VEC_TLI, PRIO_LVL3);
        ret(8'h20);
        prio_set(4'h6, PRIO_LVL3);
        ext_pins_i <= 16'h0000;
        periph_flag_i <= 9'h002;
        halt_enter_i <= 1'b1;
        @(posedge ref_clk_i);
        halt_enter_i <= 1'b0;
        wake_seen(0);
        ext_pins_i <= 16'h0002;
        wake_seen(1);
        // capable line first, the stronger peripheral right after
        serve(1, 16'hFFF6, PRIO_LVL2);
        serve(1, 16'hFFEE, PRIO_LVL3);
        wait_enter_i <= 1'b1;
        @(posedge ref_clk_i);
        wait_enter_i <= 1'b0;
        wake_seen(1);
        conclude();
    end

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            err_total++;
            conclude();
        end
    end
endmodule // nested_priority_interrupt_controller_test
